/* rtl/mcc_top.v */
// Configuration register bank and option logic of the converter controller
`timescale 1ns/10ps
`include "mcc_map.vh"
module mcc_top (
  input  wire        clk,
  input  wire        rst_b,
  // Host command port
  input  wire        cmd_wr_stb,
  input  wire        cmd_rd_stb,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  output reg  [15:0] cmd_rdata,
  output reg         cmd_rvalid,
  output reg         cmd_unsupported,
  // Nonvolatile store
  output reg         nvm_store_stb,
  output reg  [15:0] nvm_store_data,
  // Loose configuration bits of the neighbouring register
  input  wire [1:0]  vout_meas_divider_sel,
  input  wire [1:0]  vout_scale_loop_sel,
  input  wire        restore_vout_on_shutdown,
  input  wire        low_margin_restore_sel,
  input  wire        high_margin_restore_sel,
  output reg  [1:0]  vout_meas_div,
  // Shutdown causes
  input  wire        fault_shutdown_evt,
  input  wire        fault_restart_evt,
  input  wire        ctrl_shutdown_evt,
  input  wire        low_vin_evt,
  output reg         vout_cmd_restore_stb,
  // Margin registers to the reference logic
  output reg  [15:0] step_margin_high,
  output reg  [15:0] step_margin_low,
  // Overvoltage handling
  input  wire        ov_fault_evt,
  input  wire        ov_resp_ignore,
  input  wire        startup_evt,
  input  wire        disabled_state,
  input  wire        fdbk_low_0p2,
  output reg         lfet_force_on,
  // Overcurrent trim and ramp shifter
  output reg  [1:0]  high_side_overcurrent_trim,
  input  wire        drivers_switching,
  output reg         ramp_level_shifter_en,
  // Shared synchronisation pin
  input  wire        free_run_clk,
  input  wire        sync_pin_in,
  output reg         sync_pin_out,
  output reg         sync_pin_oe,
  output reg         ext_clk_sel,
  output reg         ext_clk,
  input  wire        sync_fault_raw,
  output reg         sync_fault_status,
  output reg         sync_fault_resp
);
  reg  [15:0] misc_options_reg;
  reg  [15:0] misc_options_next;
  reg  [15:0] margin_high_next;
  reg  [15:0] margin_low_next;
  reg         restore_pend_reg;
  reg         switching_d_reg;
  reg  [1:0]  div_next;
  wire [1:0]  pin_sync;
  wire        lfet_hold;
  wire        wr_misc;
  wire        wr_high;
  wire        wr_low;
  wire        do_restore;
  wire        clear_faults_stb;
  wire        shutdown_evt;

  assign wr_misc = cmd_wr_stb && (cmd_code == `MCC_CMD_MISC_OPTIONS);
  assign wr_high = cmd_wr_stb && (cmd_code == `MCC_CMD_MARGIN_HIGH);
  assign wr_low  = cmd_wr_stb && (cmd_code == `MCC_CMD_MARGIN_LOW);
  assign clear_faults_stb = cmd_wr_stb && (cmd_code == `MCC_CMD_CLEAR_FAULTS);
  // Power-on and restore-all both reload margins from the select bits
  assign do_restore = restore_pend_reg ||
                      (cmd_wr_stb && (cmd_code == `MCC_CMD_RESTORE_ALL));
  assign shutdown_evt = fault_shutdown_evt || fault_restart_evt ||
                        ctrl_shutdown_evt || low_vin_evt;

  // Feedback comparator and sync pin come from outside the clock domain
  mcc_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({sync_pin_in, fdbk_low_0p2}),
    .sync_out (pin_sync)
  );

  mcc_ov_hold u_ov_hold (
    .clk               (clk),
    .rst_b             (rst_b),
    .ov_fault_evt      (ov_fault_evt),
    .ov_resp_ignore    (ov_resp_ignore),
    .release_policy    (misc_options_reg[`MCC_BIT_OV_RELEASE]),
    .startup_evt       (startup_evt),
    .clear_faults_stb  (clear_faults_stb),
    .disabled_state    (disabled_state),
    .fdbk_low_0p2_sync (pin_sync[0]),
    .lfet_force_on     (lfet_hold)
  );

  // Register next values
  always @* begin
    misc_options_next = misc_options_reg;
    if (wr_misc)
      misc_options_next = cmd_wdata & `MCC_MISC_WMASK;
    margin_high_next = step_margin_high;
    margin_low_next  = step_margin_low;
    if (do_restore) begin
      margin_low_next = low_margin_restore_sel ? `MCC_MARGIN_LO_SEL1
                                               : `MCC_MARGIN_LO_SEL0;
      margin_high_next = high_margin_restore_sel ? `MCC_MARGIN_HI_SEL1
                                                 : `MCC_MARGIN_HI_SEL0;
    end
    if (wr_high)
      margin_high_next = cmd_wdata;
    if (wr_low)
      margin_low_next = cmd_wdata;
  end

  // Measurement divider selection
  always @* begin
    case (vout_meas_divider_sel)
      `MCC_RANGE_HALF:    div_next = `MCC_DIV_HALF;
      `MCC_RANGE_QUARTER: div_next = `MCC_DIV_QUARTER;
      `MCC_RANGE_EIGHTH:  div_next = `MCC_DIV_EIGHTH;
      default: begin
        case (vout_scale_loop_sel)
          `MCC_SCALE_ONE:     div_next = `MCC_DIV_HALF;
          `MCC_SCALE_HALF:    div_next = `MCC_DIV_QUARTER;
          `MCC_SCALE_QUARTER: div_next = `MCC_DIV_EIGHTH;
          default:            div_next = `MCC_DIV_EIGHTH;
        endcase
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_options_reg <= `MCC_MISC_RESET;
      step_margin_high <= `MCC_MARGIN_HI_SEL0;
      step_margin_low  <= `MCC_MARGIN_LO_SEL0;
      restore_pend_reg <= 1'b1;
    end else begin
      misc_options_reg <= misc_options_next;
      step_margin_high <= margin_high_next;
      step_margin_low  <= margin_low_next;
      restore_pend_reg <= 1'b0;
    end
  end

  // Command readback and nonvolatile store
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata       <= 16'h0000;
      cmd_rvalid      <= 1'b0;
      cmd_unsupported <= 1'b0;
      nvm_store_stb   <= 1'b0;
      nvm_store_data  <= 16'h0000;
    end else begin
      cmd_rvalid      <= cmd_rd_stb;
      cmd_unsupported <= 1'b0;
      if (cmd_rd_stb) begin
        case (cmd_code)
          `MCC_CMD_MARGIN_HIGH:  cmd_rdata <= step_margin_high;
          `MCC_CMD_MARGIN_LOW:   cmd_rdata <= step_margin_low;
          `MCC_CMD_MISC_OPTIONS: cmd_rdata <= misc_options_reg;
          default: begin
            cmd_rdata       <= 16'h0000;
            cmd_unsupported <= 1'b1;
          end
        endcase
      end
      nvm_store_stb <= cmd_wr_stb && (cmd_code == `MCC_CMD_STORE_ALL);
      if (cmd_wr_stb && (cmd_code == `MCC_CMD_STORE_ALL))
        nvm_store_data <= misc_options_reg;
    end
  end

  // Option outputs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vout_meas_div              <= `MCC_DIV_HALF;
      vout_cmd_restore_stb       <= 1'b0;
      lfet_force_on              <= 1'b0;
      high_side_overcurrent_trim <= 2'h0;
      switching_d_reg            <= 1'b0;
      ramp_level_shifter_en      <= 1'b0;
      sync_pin_out               <= 1'b0;
      sync_pin_oe                <= 1'b0;
      ext_clk_sel                <= 1'b0;
      ext_clk                    <= 1'b0;
      sync_fault_status          <= 1'b0;
      sync_fault_resp            <= 1'b0;
    end else begin
      vout_meas_div        <= div_next;
      vout_cmd_restore_stb <= restore_vout_on_shutdown && shutdown_evt;
      lfet_force_on        <= lfet_hold;
      high_side_overcurrent_trim <=
        misc_options_reg[`MCC_BIT_TRIM_HI:`MCC_BIT_TRIM_LO];
      switching_d_reg <= drivers_switching;
      // Sample only at the start of switching
      if (drivers_switching && !switching_d_reg)
        ramp_level_shifter_en <= misc_options_reg[`MCC_BIT_AVS_USER];
      sync_pin_oe  <= misc_options_reg[`MCC_BIT_FORCE_OUT];
      sync_pin_out <= misc_options_reg[`MCC_BIT_FORCE_OUT] & free_run_clk;
      ext_clk_sel  <= misc_options_reg[`MCC_BIT_FORCE_IN];
      ext_clk      <= misc_options_reg[`MCC_BIT_FORCE_IN] & pin_sync[1];
      sync_fault_status <= sync_fault_raw &&
                           !misc_options_reg[`MCC_BIT_SYNC_FLT_DIS];
      sync_fault_resp   <= sync_fault_raw &&
                           !misc_options_reg[`MCC_BIT_SYNC_FLT_DIS];
    end
  end
endmodule // mcc_top

/* rtl/mcc_map.vh */
// Command codes, field positions and reset values of the converter config bits
`ifndef MCC_MAP_VH
`define MCC_MAP_VH

`define MCC_CMD_MARGIN_HIGH   8'hd5
`define MCC_CMD_MARGIN_LOW    8'hd6
`define MCC_CMD_MISC_OPTIONS  8'hf0
`define MCC_CMD_STORE_ALL     8'h11
`define MCC_CMD_RESTORE_ALL   8'h12
`define MCC_CMD_CLEAR_FAULTS  8'h03

`define MCC_MISC_RESET        16'h0013
`define MCC_MISC_WMASK        16'h01d7
`define MCC_BIT_OV_RELEASE    0
`define MCC_BIT_TRIM_LO       1
`define MCC_BIT_TRIM_HI       2
`define MCC_BIT_AVS_USER      4
`define MCC_BIT_FORCE_OUT     6
`define MCC_BIT_FORCE_IN      7
`define MCC_BIT_SYNC_FLT_DIS  8

`define MCC_MARGIN_LO_SEL0    16'hfff7
`define MCC_MARGIN_LO_SEL1    16'hfff1
`define MCC_MARGIN_HI_SEL0    16'h0009
`define MCC_MARGIN_HI_SEL1    16'h000f

`define MCC_RANGE_AUTO        2'h0
`define MCC_RANGE_EIGHTH      2'h1
`define MCC_RANGE_QUARTER     2'h2
`define MCC_RANGE_HALF        2'h3
`define MCC_SCALE_ONE         2'h0
`define MCC_SCALE_HALF        2'h1
`define MCC_SCALE_QUARTER     2'h2
`define MCC_DIV_HALF          2'h1
`define MCC_DIV_QUARTER       2'h2
`define MCC_DIV_EIGHTH        2'h3

`endif

/* rtl/mcc_sync.v */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module mcc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // mcc_sync

/* rtl/mcc_ov_hold.v */
// Low-side FET hold after an output overvoltage fault
`timescale 1ns/10ps
module mcc_ov_hold (
  input  wire clk,
  input  wire rst_b,
  input  wire ov_fault_evt,
  input  wire ov_resp_ignore,
  input  wire release_policy,
  input  wire startup_evt,
  input  wire clear_faults_stb,
  input  wire disabled_state,
  input  wire fdbk_low_0p2_sync,
  output reg  lfet_force_on
);
  reg lfet_next;

  always @* begin
    lfet_next = lfet_force_on;
    if (lfet_force_on) begin
      if (!release_policy) begin
        if (startup_evt || (clear_faults_stb && disabled_state))
          lfet_next = 1'b0;
      end else if (fdbk_low_0p2_sync) begin
        lfet_next = 1'b0;
      end
    end
    // New fault wins over any release in the same cycle
    if (ov_fault_evt && !ov_resp_ignore)
      lfet_next = 1'b1;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      lfet_force_on <= 1'b0;
    else
      lfet_force_on <= lfet_next;
  end
endmodule // mcc_ov_hold

/* bench/mcc_checker.sv */
// Port assertions for the converter config bits
`timescale 1ns/10ps
module mcc_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        cmd_wr_stb,
  input wire        cmd_rd_stb,
  input wire [7:0]  cmd_code,
  input wire [15:0] cmd_rdata,
  input wire        nvm_store_stb,
  input wire [1:0]  vout_meas_divider_sel,
  input wire [1:0]  vout_scale_loop_sel,
  input wire [1:0]  vout_meas_div,
  input wire        restore_vout_on_shutdown,
  input wire        ctrl_shutdown_evt,
  input wire        vout_cmd_restore_stb,
  input wire        low_margin_restore_sel,
  input wire        high_margin_restore_sel,
  input wire [15:0] step_margin_low,
  input wire [15:0] step_margin_high,
  input wire        ov_fault_evt,
  input wire        ov_resp_ignore,
  input wire        lfet_force_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  div_fixed_a: assert property (vout_meas_divider_sel == 2'h3 |=> vout_meas_div == 2'h1)
    else $error("divider not half");
  div_auto_a: assert property ((vout_meas_divider_sel == 2'h0 &&
    vout_scale_loop_sel == 2'h2) |=> vout_meas_div == 2'h3) else $error("auto divider wrong");
  vout_restore_a: assert property (restore_vout_on_shutdown && ctrl_shutdown_evt
    |=> vout_cmd_restore_stb) else $error("no vout restore");
  margin_low_a: assert property (cmd_wr_stb && cmd_code == 8'h12 && low_margin_restore_sel
    |=> step_margin_low == 16'hfff1) else $error("low margin restore wrong");
  margin_high_a: assert property (cmd_wr_stb && cmd_code == 8'h12 && !high_margin_restore_sel
    |=> step_margin_high == 16'h0009) else $error("high margin restore wrong");
  store_pulse_a: assert property (cmd_wr_stb && cmd_code == 8'h11 |=> nvm_store_stb)
    else $error("no store pulse");
  ov_latch_a: assert property (ov_fault_evt && !ov_resp_ignore |-> ##2 lfet_force_on)
    else $error("fet not latched");
  rsvd_zero_a: assert property (cmd_rd_stb && cmd_code == 8'hf0
    |=> (cmd_rdata & 16'hfe28) == 16'h0) else $error("reserved bits set");
endmodule // mcc_checker

/* bench/mcc_host.sv */
// Host model issuing configuration commands
`timescale 1ns/10ps
module mcc_host (
  input  wire        clk,
  input  wire [15:0] cmd_rdata,
  input  wire        cmd_rvalid,
  output reg         cmd_wr_stb = 1'b0,
  output reg         cmd_rd_stb = 1'b0,
  output reg  [7:0]  cmd_code = 8'h0,
  output reg  [15:0] cmd_wdata = 16'h0
);
  task wr(input [7:0] c, input [15:0] d);
    begin
      @(negedge clk);
      cmd_code = c;
      cmd_wdata = d;
      cmd_wr_stb = 1'b1;
      @(negedge clk);
      cmd_wr_stb = 1'b0;
      cmd_code = ~c;
      cmd_wdata = ~d;
    end
  endtask
  task rd(input [7:0] c, output [15:0] d);
    integer n;
    begin
      @(negedge clk);
      cmd_code = c;
      cmd_rd_stb = 1'b1;
      @(negedge clk);
      cmd_rd_stb = 1'b0;
      cmd_code = ~c;
      for (n = 0; n < 4 && cmd_rvalid !== 1'b1; n = n + 1) @(negedge clk);
      d = cmd_rvalid ? cmd_rdata : 16'hxxxx;
    end
  endtask
endmodule // mcc_host

/* bench/tb_misc_converter_config_bits.sv */
// Self-checking bench for the converter config bits
`timescale 1ns/10ps
module tb_misc_converter_config_bits;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [1:0]  vout_meas_divider_sel, vout_scale_loop_sel;
  reg         restore_vout_on_shutdown, low_margin_restore_sel, high_margin_restore_sel;
  reg         fault_shutdown_evt, fault_restart_evt, ctrl_shutdown_evt, low_vin_evt;
  reg         ov_fault_evt, ov_resp_ignore, startup_evt, disabled_state, fdbk_low_0p2;
  reg         drivers_switching, sync_pin_in, sync_fault_raw;
  reg         free_run_clk = 1'b0;
  wire        cmd_wr_stb, cmd_rd_stb, cmd_rvalid, cmd_unsupported, nvm_store_stb;
  wire [7:0]  cmd_code;
  wire [15:0] cmd_wdata, cmd_rdata, nvm_store_data, step_margin_high, step_margin_low;
  wire [1:0]  vout_meas_div, high_side_overcurrent_trim;
  wire        vout_cmd_restore_stb, lfet_force_on, ramp_level_shifter_en, sync_pin_out;
  wire        sync_pin_oe, ext_clk_sel, ext_clk, sync_fault_status, sync_fault_resp;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     i;
  reg  [15:0] v;

  mcc_top  i_mcc_top (.*);
  mcc_host i_mcc_host (.*);

  always #50 clk = ~clk;
  always @(negedge clk) free_run_clk <= ~free_run_clk;

  task chk(input [15:0] s, input [15:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task end_sim;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task t_reset;
    begin
      chk(step_margin_high, 16'h0009);
      chk(step_margin_low, 16'hfff7);
      i_mcc_host.rd(8'hf0, v);
      chk(v, 16'h0013);
    end
  endtask
  task t_misc;
    begin
      i_mcc_host.wr(8'hf0, 16'hffff);
      i_mcc_host.rd(8'hf0, v);
      chk(v, 16'h01d7);
      sync_fault_raw = 1'b1;
      cyc(2);
      chk(sync_pin_oe, 1'b1);
      chk(ext_clk_sel, 1'b1);
      chk(sync_fault_status, 1'b0);
      chk(sync_fault_resp, 1'b0);
      sync_pin_in = 1'b1;
      cyc(4);
      chk(ext_clk, 1'b1);
      chk(sync_pin_out, free_run_clk);
      cyc(1);
      chk(sync_pin_out, free_run_clk);
      sync_pin_in = 1'b0;
      cyc(4);
      chk(ext_clk, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
        i_mcc_host.wr(8'hf0, {13'h0, i[1:0], 1'b0});
        cyc(2);
        chk(high_side_overcurrent_trim, i[1:0]);
      end
      chk(sync_pin_oe, 1'b0);
      chk(sync_pin_out, 1'b0);
      chk(ext_clk_sel, 1'b0);
      chk(sync_fault_status, 1'b1);
      chk(sync_fault_resp, 1'b1);
      sync_fault_raw = 1'b0;
    end
  endtask
  task t_store;
    begin
      i_mcc_host.wr(8'hf0, 16'h0155);
      i_mcc_host.wr(8'h11, 16'h0);
      chk(nvm_store_stb, 1'b1);
      chk(nvm_store_data, 16'h0155);
    end
  endtask
  task t_div;
    for (i = 0; i < 6; i = i + 1) begin
      vout_meas_divider_sel = (i < 3) ? i[1:0] + 2'h1 : 2'h0;
      vout_scale_loop_sel = i[1:0] - 2'h3;
      cyc(2);
      chk(vout_meas_div, (i < 3) ? 3 - i : i - 2);
    end
  endtask
  task t_margin;
    begin
      i_mcc_host.wr(8'hd5, 16'h1234);
      i_mcc_host.wr(8'hd6, 16'hfedc);
      i_mcc_host.rd(8'hd5, v);
      chk(v, 16'h1234);
      i_mcc_host.rd(8'hd6, v);
      chk(v, 16'hfedc);
      {low_margin_restore_sel, high_margin_restore_sel} = 2'h3;
      i_mcc_host.wr(8'h12, 16'h0);
      chk(step_margin_low, 16'hfff1);
      chk(step_margin_high, 16'h000f);
      {low_margin_restore_sel, high_margin_restore_sel} = 2'h0;
      i_mcc_host.wr(8'h12, 16'h0);
      chk(step_margin_low, 16'hfff7);
      chk(step_margin_high, 16'h0009);
    end
  endtask
  task t_shut;
    for (i = 0; i < 5; i = i + 1) begin
      restore_vout_on_shutdown = (i != 0);
      {fault_shutdown_evt, fault_restart_evt, ctrl_shutdown_evt, low_vin_evt} =
        (i == 0) ? 4'hf : 4'h1 << i[1:0];
      cyc(1);
      {fault_shutdown_evt, fault_restart_evt, ctrl_shutdown_evt, low_vin_evt} = 4'h0;
      chk(vout_cmd_restore_stb, i != 0);
      cyc(1);
      chk(vout_cmd_restore_stb, 1'b0);
    end
  endtask
  task t_ov;
    for (i = 0; i < 3; i = i + 1) begin
      i_mcc_host.wr(8'hf0, {15'h0, i == 2});
      ov_resp_ignore = (i == 0);
      ov_fault_evt = 1'b1;
      cyc(1);
      ov_fault_evt = 1'b0;
      cyc(3);
      chk(lfet_force_on, i != 0);
      fdbk_low_0p2 = (i != 0);
      cyc(6);
      chk(lfet_force_on, i == 1);
      fdbk_low_0p2 = 1'b0;
      if (i == 1) begin
        i_mcc_host.wr(8'h03, 16'h0);
        cyc(2);
        chk(lfet_force_on, 1'b1);
        disabled_state = 1'b1;
        i_mcc_host.wr(8'h03, 16'h0);
        disabled_state = 1'b0;
        cyc(2);
        chk(lfet_force_on, 1'b0);
      end
      startup_evt = 1'b1;
      cyc(1);
      startup_evt = 1'b0;
      cyc(3);
      chk(lfet_force_on, 1'b0);
    end
  endtask
  task t_avs;
    begin
      i_mcc_host.wr(8'hf0, 16'h0010);
      drivers_switching = 1'b1;
      cyc(3);
      chk(ramp_level_shifter_en, 1'b1);
      i_mcc_host.wr(8'hf0, 16'h0);
      cyc(2);
      chk(ramp_level_shifter_en, 1'b1);
      drivers_switching = 1'b0;
      cyc(2);
      drivers_switching = 1'b1;
      cyc(3);
      chk(ramp_level_shifter_en, 1'b0);
    end
  endtask

  initial begin
    {vout_meas_divider_sel, vout_scale_loop_sel, restore_vout_on_shutdown,
     low_margin_restore_sel, high_margin_restore_sel, fault_shutdown_evt,
     fault_restart_evt, ctrl_shutdown_evt, low_vin_evt, ov_fault_evt, ov_resp_ignore,
     startup_evt, disabled_state, fdbk_low_0p2, drivers_switching,
     sync_pin_in, sync_fault_raw} = 19'h0;
    cyc(20);
    rst_b = 1'b1;
    cyc(2);
    t_reset;
    t_misc;
    t_store;
    t_div;
    t_margin;
    t_shut;
    t_ov;
    t_avs;
    end_sim;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    end_sim;
  end
endmodule // tb_misc_converter_config_bits

bind mcc_top mcc_checker i_mcc_checker (.*);
